// >>> optical_sensor_interrupt_flags.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "optical_irq_map.svh"

module optical_sensor_interrupt_flags
	import optical_irq_pkg::*;
#(
	parameter int unsigned ADC_W    = 19,
	parameter int unsigned THRESH_W = 8,
	parameter int unsigned CLK_HZ   = `CLOCK_HZ,
	parameter int unsigned PILOT_HZ = `PILOT_RATE_HZ
) (
	// Clock and reset
	input  wire logic                REF_CLK,
	input  wire logic                RESET_N,
	// Register port
	input  wire logic [7:0]          REG_ADDR,
	input  wire logic [7:0]          REG_WDATA,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	output logic      [7:0]          REG_RDATA,
	// Event sources from the acquisition core
	input  wire logic                AMBIENT_LIMIT,
	input  wire logic                SAMPLE_END,
	input  wire logic                LED_NONCOMPLIANT,
	input  wire logic                TEMP_DONE,
	input  wire logic                TEMP_DATA_READ,
	input  wire logic                SUPPLY_UNDERVOLTAGE,
	input  wire logic                AUTH_DONE,
	input  wire logic                BUFFER_ALMOST_FULL,
	input  wire logic                BUFFER_PUSH,
	input  wire logic                SHUTDOWN_WRITE,
	// Proximity detection inputs
	input  wire logic                FIRST_SLOT_VALID,
	input  wire logic [ADC_W-1:0]    FIRST_SLOT_RESULT,
	input  wire logic [THRESH_W-1:0] PROXIMITY_THRESHOLD,
	// Acquisition control
	output logic                     SEQUENCE_START,
	output logic                     PILOT_MODE,
	output logic                     PILOT_SAMPLE_TICK,
	output logic                     ALL_EXPOSURES,
	// Interrupt
	output logic                     IRQ
);

	localparam int unsigned PILOT_DIV = CLK_HZ / PILOT_HZ;
	localparam int unsigned DIV_W     = $clog2(PILOT_DIV);
	localparam int unsigned PROD_W    = THRESH_W + 12;

	////////////////////////////////////////////////////////////////////////
	reg8_t      status_pri_q;
	reg8_t      status_sec_q;
	reg8_t      enable_pri_q;
	reg8_t      enable_sec_q;
	reg8_t      rdata_q;
	acq_state_t state_q;
	acq_state_t state_d;
	logic [DIV_W-1:0] div_q;
	logic       prox_en;
	logic       rd_pri;
	logic       rd_sec;
	logic       prox_event;
	logic       near_hit;
	logic [PROD_W-1:0] limit;

	assign prox_en = enable_pri_q[`BIT_PROXIMITY];
	assign rd_pri  = REG_RD && (REG_ADDR == `OFS_STATUS_PRI);
	assign rd_sec  = REG_RD && (REG_ADDR == `OFS_STATUS_SEC);

	////////////////////////////////////////////////////////////////////////
	// Enable registers
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			enable_pri_q <= `RST_ENABLE;
			enable_sec_q <= `RST_ENABLE;
		end else if (REG_WR) begin
			if (REG_ADDR == `OFS_ENABLE_PRI)
				enable_pri_q <= REG_WDATA & 8'hfc;
			if (REG_ADDR == `OFS_ENABLE_SEC)
				enable_sec_q <= REG_WDATA & 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Proximity decision: result below threshold scaled by 2048
	assign limit    = PROD_W'(PROXIMITY_THRESHOLD) * PROD_W'(`PROX_SCALE);
	assign near_hit = (PROD_W'(FIRST_SLOT_RESULT) < limit);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ACQ_IDLE: begin
				if (prox_en && FIRST_SLOT_VALID)
					state_d = near_hit ? ACQ_PILOT : ACQ_NORMAL;
			end
			ACQ_PILOT: begin
				if (FIRST_SLOT_VALID && !near_hit)
					state_d = ACQ_NORMAL;
			end
			ACQ_NORMAL: begin
				if (FIRST_SLOT_VALID && near_hit)
					state_d = ACQ_PILOT;
			end
			default: state_d = ACQ_IDLE;
		endcase
		if (!prox_en)
			state_d = ACQ_IDLE;
	end

	// Mode changes only while proximity is enabled, so disabling silences the event
	assign prox_event = prox_en && (state_d != state_q) && (state_d != ACQ_IDLE);

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			state_q <= ACQ_IDLE;
		else
			state_q <= state_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Acquisition control outputs
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			SEQUENCE_START <= 1'b0;
			PILOT_MODE     <= 1'b0;
			ALL_EXPOSURES  <= 1'b0;
		end else begin
			// Without proximity the full sequence runs straight away
			SEQUENCE_START <= !prox_en || (state_d == ACQ_NORMAL);
			PILOT_MODE     <= (state_d == ACQ_PILOT);
			ALL_EXPOSURES  <= !prox_en || (state_d == ACQ_NORMAL);
		end
	end

	// Pilot sampling tick from a divider held at zero outside pilot mode, one cycle per period
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_q             <= '0;
			PILOT_SAMPLE_TICK <= 1'b0;
		end else if (state_q != ACQ_PILOT) begin
			div_q             <= '0;
			PILOT_SAMPLE_TICK <= 1'b0;
		end else if (div_q == DIV_W'(PILOT_DIV - 1)) begin
			div_q             <= '0;
			PILOT_SAMPLE_TICK <= 1'b1;
		end else begin
			div_q             <= div_q + 1'b1;
			PILOT_SAMPLE_TICK <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Primary status: set wins over clear in the same cycle
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			status_pri_q <= `RST_STATUS;
		end else begin
			if (rd_pri)
				status_pri_q <= `RST_STATUS;
			if (TEMP_DATA_READ)
				status_pri_q[`BIT_TEMP_READY] <= 1'b0;
			if (SHUTDOWN_WRITE)
				status_pri_q[`BIT_POWER_READY] <= 1'b0;
			if (BUFFER_ALMOST_FULL)
				status_pri_q[`BIT_ALMOST_FULL] <= 1'b1;
			if (BUFFER_PUSH)
				status_pri_q[`BIT_DATA_READY] <= 1'b1;
			if (AMBIENT_LIMIT)
				status_pri_q[`BIT_AMBIENT_OVF] <= 1'b1;
			if (prox_event)
				status_pri_q[`BIT_PROXIMITY] <= 1'b1;
			if (SAMPLE_END && LED_NONCOMPLIANT && enable_pri_q[`BIT_LED_NONCOMP])
				status_pri_q[`BIT_LED_NONCOMP] <= 1'b1;
			if (TEMP_DONE)
				status_pri_q[`BIT_TEMP_READY] <= 1'b1;
			// Soft reset has no path here; only the supply monitor sets it
			if (SUPPLY_UNDERVOLTAGE)
				status_pri_q[`BIT_POWER_READY] <= 1'b1;
		end
	end

	// Secondary status
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			status_sec_q <= `RST_STATUS;
		else if (AUTH_DONE)
			status_sec_q[`BIT_AUTH_DONE] <= 1'b1;
		else if (rd_sec)
			status_sec_q <= `RST_STATUS;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			rdata_q <= 8'h00;
		else if (REG_RD) begin
			unique case (REG_ADDR)
				`OFS_STATUS_PRI: rdata_q <= status_pri_q;
				`OFS_STATUS_SEC: rdata_q <= status_sec_q;
				`OFS_ENABLE_PRI: rdata_q <= enable_pri_q;
				`OFS_ENABLE_SEC: rdata_q <= enable_sec_q;
				default:         rdata_q <= 8'h00;
			endcase
		end else
			rdata_q <= 8'h00;
	end
	assign REG_RDATA = rdata_q;

	// Power flag has no enable bit, so it never raises the request line
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N)
			IRQ <= 1'b0;
		else
			IRQ <= |(status_pri_q & enable_pri_q) | |(status_sec_q & enable_sec_q);
	end

endmodule
`default_nettype wire

// >>> optical_irq_map.svh
`ifndef OPTICAL_IRQ_MAP_SVH
`define OPTICAL_IRQ_MAP_SVH

// Register offsets
`define OFS_STATUS_PRI      8'h00
`define OFS_STATUS_SEC      8'h01
`define OFS_ENABLE_PRI      8'h02
`define OFS_ENABLE_SEC      8'h03

// Primary status and enable bit positions, and the secondary auth bit
`define BIT_ALMOST_FULL     7
`define BIT_DATA_READY      6
`define BIT_AMBIENT_OVF     5
`define BIT_PROXIMITY       4
`define BIT_LED_NONCOMP     3
`define BIT_TEMP_READY      2
`define BIT_POWER_READY     0
`define BIT_AUTH_DONE       0

// Reset values
`define RST_STATUS          8'h00
`define RST_ENABLE          8'h00

// Proximity decision scale, pilot rate and clock frequency
`define PROX_SCALE          2048
`define PILOT_RATE_HZ       8
`define CLOCK_HZ            250000000

`endif

// >>> optical_irq_pkg.sv
package optical_irq_pkg;

	typedef enum logic [2:0] {
		ACQ_IDLE   = 3'b001,
		ACQ_PILOT  = 3'b010,
		ACQ_NORMAL = 3'b100
	} acq_state_t;

	typedef logic [7:0] reg8_t;

endpackage

// >>> irq_flags_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module irq_flags_chk (
	// Clock and reset
	input wire logic       REF_CLK,
	input wire logic       RESET_N,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_RDATA,
	// Events and mode
	input wire logic       AMBIENT_LIMIT,
	input wire logic       TEMP_DONE,
	input wire logic       TEMP_DATA_READ,
	input wire logic       SUPPLY_UNDERVOLTAGE,
	input wire logic       SHUTDOWN_WRITE,
	input wire logic       AUTH_DONE,
	input wire logic       SEQUENCE_START,
	input wire logic       PILOT_MODE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	sequence s_rd0; REG_RD && REG_ADDR == 8'h00; endsequence
	sequence s_rd1; REG_RD && REG_ADDR == 8'h01; endsequence
	property p_amb; AMBIENT_LIMIT ##1 s_rd0 |=> REG_RDATA[5]; endproperty
	a_amb: assert property (p_amb) else $error("ambient flag lost");
	property p_clr; s_rd0 ##0 !AMBIENT_LIMIT [*2] ##1 s_rd0 |=> !REG_RDATA[5]; endproperty
	a_clr: assert property (p_clr) else $error("ambient flag kept");
	property p_tmp; TEMP_DATA_READ && !TEMP_DONE ##1 s_rd0 |=> !REG_RDATA[2]; endproperty
	a_tmp: assert property (p_tmp) else $error("temp flag kept");
	property p_pwr; SUPPLY_UNDERVOLTAGE ##1 s_rd0 |=> REG_RDATA[0]; endproperty
	a_pwr: assert property (p_pwr) else $error("power flag lost");
	property p_shd; SHUTDOWN_WRITE && !SUPPLY_UNDERVOLTAGE ##1 s_rd0 |=> !REG_RDATA[0]; endproperty
	a_shd: assert property (p_shd) else $error("power flag kept");
	property p_ath; AUTH_DONE ##1 s_rd1 |=> REG_RDATA == 8'h01; endproperty
	a_ath: assert property (p_ath) else $error("auth flag wrong");
	property p_en;
		REG_WR && REG_ADDR == 8'h02 ##1 REG_RD && REG_ADDR == 8'h02
			|=> REG_RDATA == ($past(REG_WDATA, 2) & 8'hfc);
	endproperty
	a_en: assert property (p_en) else $error("enable readback wrong");
	// Pilot and full sequence must never run together
	property p_mode; !(PILOT_MODE && SEQUENCE_START); endproperty
	a_mode: assert property (p_mode) else $error("both modes active");
endmodule
bind optical_sensor_interrupt_flags irq_flags_chk irq_flags_chk_inst (.*);
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Clock
	input  wire logic       clk,
	// Register port
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	initial begin
		{addr, wdata, wr, rd} = 18'h0;
	end
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stands one cycle only, so taken at the edge closing it
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import optical_irq_pkg::*;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [10:0] ev = 11'h0;
	logic [18:0] res = 19'h0;
	logic [7:0]  thr = 8'h00;
	logic [7:0]  addr, wdata, rdata, d, t;
	logic        wr, rd, seq, pil, irq, alx, tick;
	logic [7:0]  nt;
	logic [31:0] seed = 32'h5321e740;
	int          err_total = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #2 clk = ~clk;
	host_model host_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	optical_sensor_interrupt_flags #(.CLK_HZ(80), .PILOT_HZ(8)) optical_sensor_interrupt_flags_inst (
		.REF_CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .AMBIENT_LIMIT(ev[0]),
		.TEMP_DONE(ev[1]), .SUPPLY_UNDERVOLTAGE(ev[2]), .BUFFER_PUSH(ev[3]),
		.BUFFER_ALMOST_FULL(ev[4]), .SAMPLE_END(ev[5]), .LED_NONCOMPLIANT(ev[6]),
		.AUTH_DONE(ev[7]), .TEMP_DATA_READ(ev[8]), .SHUTDOWN_WRITE(ev[9]),
		.FIRST_SLOT_VALID(ev[10]), .FIRST_SLOT_RESULT(res), .PROXIMITY_THRESHOLD(thr),
		.SEQUENCE_START(seq), .PILOT_MODE(pil), .PILOT_SAMPLE_TICK(tick),
		.ALL_EXPOSURES(alx), .IRQ(irq));
	function automatic logic [31:0] nx();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Unimplemented enable bits read back as zero
	function automatic reg8_t en_exp(input reg8_t a, input reg8_t v);
		return (a == 8'h02) ? (v & 8'hfc) : (v & 8'h01);
	endfunction
	task automatic chk(input reg8_t s, input reg8_t e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic pulse(input logic [10:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 11'h0;
	endtask
	task automatic rdchk(input reg8_t a, input reg8_t e);
		host_model_inst.reg_read(a, d);
		chk(d, e);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			give_verdict();
		end
	end
	localparam logic [10:0] MK[6] = '{11'h1, 11'h2, 11'h4, 11'h8, 11'h10, 11'h60};
	localparam int          BT[6] = '{5, 2, 0, 6, 7, 3};
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int a = 0; a < 4; a++) rdchk(a[7:0], 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			t = nx();
			host_model_inst.reg_write(8'h02 + i[0], t);
			rdchk(8'h02 + i[0], en_exp(8'h02 + i[0], t));
		end
		host_model_inst.reg_write(8'h03, 8'h00);
		// Edge between writes so the strobe is not driven twice in one step
		@(posedge clk);
		host_model_inst.reg_write(8'h02, 8'h08);
		for (int i = 0; i < 6; i++) begin
			pulse(MK[i]);
			rdchk(8'h00, 8'h01 << BT[i]);
			rdchk(8'h00, 8'h00);
		end
		host_model_inst.reg_write(8'h02, 8'h00);
		pulse(11'h060);
		rdchk(8'h00, 8'h00);
		pulse(11'h002);
		@(posedge clk);
		pulse(11'h100);
		rdchk(8'h00, 8'h00);
		pulse(11'h004);
		@(posedge clk);
		pulse(11'h200);
		rdchk(8'h00, 8'h00);
		pulse(11'h080);
		rdchk(8'h01, 8'h01);
		rdchk(8'h01, 8'h00);
		$display("event test done");
		host_model_inst.reg_write(8'h02, 8'h20);
		pulse(11'h001);
		repeat (2) @(posedge clk);
		chk(irq, 1'b1);
		rdchk(8'h00, 8'h20);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("irq test done");
		// Threshold kept nonzero so a strictly lower result exists
		thr <= nx() | 8'h01;
		host_model_inst.reg_write(8'h02, 8'h10);
		res <= {thr, 11'h0} - 19'h1;
		pulse(11'h400);
		rdchk(8'h00, 8'h10);
		chk({pil, seq, alx}, 3'b100);
		// Pilot tick every CLK_HZ/PILOT_HZ = 10 cycles, so 40 cycles hold 4
		nt = 8'h00;
		repeat (40) begin
			@(posedge clk);
			nt = nt + {7'h0, tick};
		end
		chk(nt, 8'h04);
		res <= {thr, 11'h0};
		pulse(11'h400);
		rdchk(8'h00, 8'h10);
		chk({pil, seq, alx}, 3'b011);
		host_model_inst.reg_write(8'h02, 8'h00);
		res <= 19'h0;
		pulse(11'h400);
		rdchk(8'h00, 8'h00);
		chk({pil, seq, alx}, 3'b011);
		$display("proximity test done");
		give_verdict();
	end
endmodule
`default_nettype wire
